// File: src/sar_adc_control.sv
`timescale 1ns/1ps
// Operation
// - Converter runs only while enable is one.
// - Reference and channel applied only once enabled.
// - Result is the 16-bit sum of samples, right aligned.
// - Start by software command or routed event.
// - Window compare gates the interrupt by threshold.
// - Sum up to sixty-four samples per result.
// - Inter-sample delay with optional random variation.
// - Converter clock from internal peripheral clock prescaler.
// - Debug halt stops block unless debug-run set.
// - Debug-run set keeps block running when halted.
// - Single or free-running mode by control bit.
// - Resolution select: 10-bit or 8-bit, both taking the same thirteen cycles.
// - Reference defaults to internal source after reset.
// - Writing start command one begins a conversion.
// - Interrupt on completion only when source enabled.
// - Event start enable lets events start conversions.
// - Start bit reads one while converting.
// - Conversion takes thirteen converter clock cycles.
// - Ready flag set on done; cleared by read/write-one.
// - Free-running restarts immediately after each completion.
module sar_adc_control
   import sar_ctrl_pkg::*;
#(
   parameter int CH_WIDTH = CH_W
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Configuration
   input wire logic enable_i,
   input wire logic resolution_select_i,
   input wire logic free_running_enable_i,
   input wire logic [ACC_SEL_W-1:0] accumulation_count_select_i,
   input wire logic [1:0] reference_select_i,
   input wire logic [DIV_SEL_W-1:0] clock_divider_select_i,
   input wire logic [CH_W-1:0] input_channel_select_i,
   input wire logic event_start_enable_i,
   input wire logic debug_run_enable_i,
   input wire logic [DLY_W-1:0] sample_delay_i,
   input wire logic sample_delay_random_i,
   input wire window_cfg_s window_cfg_i,
   input wire logic result_ready_int_enable_i,
   // Commands
   input wire logic start_conversion_cmd_i,
   input wire logic result_read_i,
   input wire logic result_ready_clear_i,
   input wire logic debug_halt_i,
   input wire logic event_i,
   // Analog core
   input wire logic [RES_W-1:0] sar_data_i,
   // Status and analog controls
   output logic start_conversion_cmd_o,
   output logic [ACC_W-1:0] result_o,
   output logic result_ready_flag_o,
   output logic window_flag_o,
   output logic irq_o,
   output logic adc_clk_o,
   output logic sample_o,
   output logic low_res_o,
   output analog_sel_s analog_sel_o
);

   // ----------------------------------------------------------------
   // Synchronisers and start detection
   // ----------------------------------------------------------------
   logic ev_meta_ff, ev_sync_ff, ev_prev_ff;
   logic halt_meta_ff, halt_sync_ff;

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ev_meta_ff <= 1'b0;
         ev_sync_ff <= 1'b0;
         ev_prev_ff <= 1'b0;
         halt_meta_ff <= 1'b0;
         halt_sync_ff <= 1'b0;
      end else begin
         ev_meta_ff <= event_i;
         ev_sync_ff <= ev_meta_ff;
         ev_prev_ff <= ev_sync_ff;
         halt_meta_ff <= debug_halt_i;
         halt_sync_ff <= halt_meta_ff;
      end
   end

   // Events are edge sensitive, so a held event line starts one conversion.
   wire ev_edge = ev_sync_ff & ~ev_prev_ff;
   wire run_ok = enable_i & (~halt_sync_ff | debug_run_enable_i);
   wire ev_start = ev_edge & event_start_enable_i;

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   conv_state_e state_ff, nxt_state;
   logic busy_ff;
   logic [7:0] pre_cnt_ff;
   logic adc_clk_ff;

   // Divide by 2, 4, ... 256; the counter stays in reset while idle.
   // Holding it in reset gives a fixed delay from a start to the first tick.
   // A halt only freezes the counter, so a halted conversion resumes in place.
   wire [7:0] pre_half = 8'(8'h01 << clock_divider_select_i);
   wire pre_wrap = (pre_cnt_ff == pre_half - 8'h01);
   wire adc_tick = busy_ff & run_ok & pre_wrap & adc_clk_ff;

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i || !enable_i || !busy_ff) begin
         pre_cnt_ff <= 8'h00;
         adc_clk_ff <= 1'b0;
      end else if (run_ok) begin
         pre_cnt_ff <= pre_wrap ? 8'h00 : pre_cnt_ff + 8'h01;
         adc_clk_ff <= pre_wrap ? ~adc_clk_ff : adc_clk_ff;
      end
   end

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   logic [3:0] cyc_ff;
   logic [6:0] smp_ff;
   logic [DLY_W-1:0] dly_ff;
   logic [15:0] lfsr_ff;
   logic [ACC_W-1:0] acc_ff;
   logic [ACC_W-1:0] res_ff;
   logic rdy_ff, win_ff, irq_ff, samp_ff;
   logic low_res_ff;
   analog_sel_s sel_ff;

   // Codes above six would ask for more than 64 samples, so they clamp to 64.
   wire [ACC_SEL_W-1:0] acc_sel = (accumulation_count_select_i > ACC_SEL_W'(6)) ?
      ACC_SEL_W'(6) : accumulation_count_select_i;
   wire [6:0] n_samples = 7'(7'h01 << acc_sel);
   wire last_sample = (smp_ff == n_samples - 7'h01);
   wire conv_done = (state_ff == ST_CONV) & adc_tick & (cyc_ff == CNV_LAST);
   wire burst_done = conv_done & last_sample;
   wire sw_start = start_conversion_cmd_i & run_ok;
   wire start_req = ~busy_ff & (sw_start | (ev_start & run_ok));
   // Free-running restarts on completion without a fresh command.
   wire restart = burst_done & free_running_enable_i;
   wire [RES_W-1:0] sample_val = resolution_select_i ?
      {2'b00, sar_data_i[RES_W-1:2]} : sar_data_i;
   wire [ACC_W-1:0] sum_val = acc_ff + ACC_W'(sample_val);
   wire [DLY_W-1:0] dly_load = sample_delay_random_i ?
      (sample_delay_i ^ lfsr_ff[DLY_W-1:0]) : sample_delay_i;
   wire [RES_W-1:0] cmp_val = sum_val[RES_W-1:0];
   wire below = cmp_val < window_cfg_i.low;
   wire above = cmp_val > window_cfg_i.high;
   logic win_hit;

   always_comb begin
      case (window_cfg_i.mode)
         WIN_NONE: win_hit = 1'b1;
         WIN_BELOW: win_hit = below;
         WIN_ABOVE: win_hit = above;
         WIN_INSIDE: win_hit = ~below & ~above;
         WIN_OUTSIDE: win_hit = below | above;
         default: win_hit = 1'b1;
      endcase
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (start_req) nxt_state = ST_CONV;
         ST_DELAY: if (adc_tick && dly_ff == '0) nxt_state = ST_CONV;
         ST_CONV: begin
            if (conv_done) begin
               if (!last_sample) nxt_state = ST_DELAY;
               else if (!restart) nxt_state = ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
      if (!enable_i) nxt_state = ST_IDLE;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         state_ff <= ST_IDLE;
         busy_ff <= 1'b0;
         cyc_ff <= 4'h0;
         smp_ff <= 7'h00;
         dly_ff <= '0;
         lfsr_ff <= LFSR_SEED;
         acc_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         busy_ff <= (nxt_state != ST_IDLE);
         lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
         if (state_ff == ST_IDLE) begin
            cyc_ff <= 4'h0;
            smp_ff <= 7'h00;
            acc_ff <= '0;
         end else if (conv_done) begin
            cyc_ff <= 4'h0;
            smp_ff <= last_sample ? 7'h00 : smp_ff + 7'h01;
            acc_ff <= last_sample ? '0 : sum_val;
            dly_ff <= dly_load;
         end else if (adc_tick) begin
            if (state_ff == ST_CONV) cyc_ff <= cyc_ff + 4'h1;
            else if (dly_ff != '0) dly_ff <= dly_ff - DLY_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // Result, flags and analog selections
   // ----------------------------------------------------------------
   // Selections track the inputs only while enabled and not in conversion cycles 0 to 10.
   wire sel_open = enable_i & ((state_ff != ST_CONV) | (cyc_ff >= LOCK_END));

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         res_ff <= '0;
         rdy_ff <= 1'b0;
         win_ff <= 1'b0;
         irq_ff <= 1'b0;
         samp_ff <= 1'b0;
         low_res_ff <= 1'b0;
         sel_ff <= '{reference_select: REF_INTERNAL, input_channel_select: '0};
      end else begin
         if (burst_done) res_ff <= sum_val;
         // A completion in the same cycle as a clear keeps the flag set.
         if (burst_done) rdy_ff <= 1'b1;
         else if (result_read_i || result_ready_clear_i) rdy_ff <= 1'b0;
         if (burst_done && win_hit) win_ff <= 1'b1;
         else if (result_read_i || result_ready_clear_i) win_ff <= 1'b0;
         irq_ff <= result_ready_int_enable_i & (burst_done ? win_hit : win_ff);
         samp_ff <= (state_ff == ST_CONV) & (cyc_ff < 4'h2);
         low_res_ff <= resolution_select_i;
         if (sel_open) begin
            sel_ff.reference_select <= reference_select_i;
            sel_ff.input_channel_select <= input_channel_select_i;
         end
      end
   end

   assign start_conversion_cmd_o = busy_ff;
   assign result_o = res_ff;
   assign result_ready_flag_o = rdy_ff;
   assign window_flag_o = win_ff;
   assign irq_o = irq_ff;
   assign adc_clk_o = adc_clk_ff;
   assign sample_o = samp_ff;
   assign low_res_o = low_res_ff;
   assign analog_sel_o = sel_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_done;
      burst_done;
   endsequence

   a_disabled_idle: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !enable_i |=> !busy_ff) else $error("busy while disabled");
   a_start_busy: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (sw_start && !busy_ff && enable_i) |=> start_conversion_cmd_o)
      else $error("start not taken");
   a_ready_sets: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      s_done |=> result_ready_flag_o) else $error("ready not set");
   a_ready_clear: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (result_read_i && !burst_done) |=> !result_ready_flag_o)
      else $error("ready not cleared");
   a_single_ends: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (s_done and !free_running_enable_i) |=> !start_conversion_cmd_o)
      else $error("single mode did not stop");
   a_free_runs: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (s_done and free_running_enable_i and enable_i) |=> start_conversion_cmd_o)
      else $error("free-running stopped");
   a_halt_freeze: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (halt_sync_ff && !debug_run_enable_i) |-> !adc_tick) else $error("ran in halt");
   a_irq_gate: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !result_ready_int_enable_i |=> !irq_o) else $error("irq while disabled");
   a_conv_len: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      conv_done |-> cyc_ff == 4'hc) else $error("conversion length wrong");
   a_no_event: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (!busy_ff && !event_start_enable_i && !start_conversion_cmd_i) |=> !busy_ff)
      else $error("unenabled event started");
   a_burst_last: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (conv_done && !last_sample) |=> !result_ready_flag_o || $past(rdy_ff))
      else $error("ready mid burst");

   // ----------------------------------------------------------------
   // Checks on selections, clocking and halt
   // ----------------------------------------------------------------
   // Locked selections keep the sampled channel steady during the sample.
   sequence s_locked;
      enable_i && (state_ff == ST_CONV) && (cyc_ff < LOCK_END);
   endsequence

   sequence s_taken;
      !busy_ff && run_ok && (sw_start || ev_start);
   endsequence

   // Independent count of converter ticks, so the length check
   // does not lean on the sequencer's own counter.
   logic [3:0] chk_ticks_ff;

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i || state_ff != ST_CONV || conv_done) begin
         chk_ticks_ff <= 4'h0;
      end else if (adc_tick) begin
         chk_ticks_ff <= chk_ticks_ff + 4'h1;
      end
   end

   a_tick_count: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      conv_done |-> chk_ticks_ff == 4'(CNV_CYCLES - 1)) else $error("tick count wrong");
   a_sel_locked: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      s_locked |=> $stable(analog_sel_o)) else $error("selection moved in sample");
   a_sel_off: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !enable_i |=> $stable(analog_sel_o)) else $error("selection moved while off");
   a_clk_idle: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      !busy_ff |=> !adc_clk_o) else $error("converter clock ran idle");
   a_ready_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (result_ready_flag_o && !result_read_i && !result_ready_clear_i) |=>
      result_ready_flag_o) else $error("ready dropped");
   a_res_narrow: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (burst_done && resolution_select_i) |=> result_o < 16'(MAX_ACC * 256))
      else $error("low resolution result too wide");
   a_burst_bound: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      busy_ff |-> smp_ff < 7'(MAX_ACC)) else $error("too many samples");
   a_taken_busy: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      s_taken |=> start_conversion_cmd_o) else $error("start request lost");
   a_irq_window: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (burst_done && !win_hit) |=> !irq_o) else $error("irq outside window");
   a_halt_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (halt_sync_ff && !debug_run_enable_i && busy_ff && enable_i) |=> $stable(cyc_ff))
      else $error("conversion moved in halt");
   a_debug_run: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (halt_sync_ff && debug_run_enable_i && sw_start && !busy_ff) |=>
      start_conversion_cmd_o) else $error("debug run start lost");
   a_idle_stays: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (!busy_ff && !start_req) |=> !busy_ff) else $error("started without request");

endmodule

// File: src/sar_ctrl_pkg.sv
package sar_ctrl_pkg;

   // ----------------------------------------------------------------
   // Widths and counts
   // ----------------------------------------------------------------
   localparam int RES_W = 10;
   localparam int ACC_W = 16;
   localparam int CH_W = 5;
   localparam int DIV_SEL_W = 3;
   localparam int ACC_SEL_W = 3;
   localparam int DLY_W = 4;
   localparam int CNV_CYCLES = 13;
   localparam int MAX_ACC = 64;
   localparam logic [3:0] CNV_LAST = 4'hc;
   localparam logic [3:0] LOCK_END = 4'hb;
   localparam logic [1:0] REF_INTERNAL = 2'h0;
   localparam logic [15:0] LFSR_SEED = 16'hace1;

   // ----------------------------------------------------------------
   // Window compare modes
   // ----------------------------------------------------------------
   localparam logic [2:0] WIN_NONE = 3'h0;
   localparam logic [2:0] WIN_BELOW = 3'h1;
   localparam logic [2:0] WIN_ABOVE = 3'h2;
   localparam logic [2:0] WIN_INSIDE = 3'h3;
   localparam logic [2:0] WIN_OUTSIDE = 3'h4;

   typedef struct packed {
      logic [1:0] reference_select;
      logic [CH_W-1:0] input_channel_select;
   } analog_sel_s;

   typedef struct packed {
      logic [2:0] mode;
      logic [RES_W-1:0] low;
      logic [RES_W-1:0] high;
   } window_cfg_s;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DELAY,
      ST_CONV
   } conv_state_e;

endpackage

// File: bench/sar_analog_model.sv
`timescale 1ns/1ps
module sar_analog_model
   import sar_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Converter controls
   input wire logic sample_i,
   input wire analog_sel_s analog_sel_i,
   // Conversion code
   output logic [RES_W-1:0] sar_data_o
);
   // ----------------------------------------------------------------
   // Sample and hold
   // ----------------------------------------------------------------
   // Codes sit near full scale so that long bursts stress the width of the sum.
   logic [RES_W-1:0] held_ff;
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         held_ff <= 10'h155;
      end else if (sample_i) begin
         held_ff <= 10'h3e0 + RES_W'(analog_sel_i.input_channel_select);
      end
   end
   assign sar_data_o = held_ff;
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module testbench;
   import sar_ctrl_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus, rows and observed outputs
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] acc;
      logic [2:0] div;
      logic [3:0] dly;
      logic res8;
      logic [4:0] ch;
      window_cfg_s win;
      logic int_en;
      logic exp_irq;
   } row_s;
   row_s rows[4] = '{
      '{3'h0, 3'h0, 4'h0, 1'b0, 5'h01, '{WIN_BELOW, 10'h3ff, 10'h000}, 1'b1, 1'b1},
      '{3'h1, 3'h1, 4'h2, 1'b1, 5'h02, '{WIN_ABOVE, 10'h000, 10'h100}, 1'b1, 1'b1},
      '{3'h3, 3'h0, 4'h1, 1'b0, 5'h1f, '{WIN_INSIDE, 10'h000, 10'h010}, 1'b1, 1'b0},
      '{3'h6, 3'h0, 4'h0, 1'b0, 5'h1f, '{WIN_OUTSIDE, 10'h000, 10'h010}, 1'b0, 1'b0}};
   row_s cur = '0;
   logic sys_clk_i = 0, reset_n_i = 0, en = 0, free = 0, ev_en = 0, dbg_run = 0, rnd = 0;
   logic start = 0, rd = 0, clr = 0, halt = 0, ev = 0;
   logic [1:0] ref_sel = 2'h0;
   logic [9:0] sar_data, d;
   logic busy, ready, win_flag, irq, adc_clk, sample, low_res;
   logic [15:0] result;
   analog_sel_s sel;
   int failures = 0, cmp_count = 0, cyc, n, lo;

   initial forever #5 sys_clk_i = ~sys_clk_i;

   sar_adc_control u_sar_adc_control (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .enable_i(en),
      .resolution_select_i(cur.res8), .free_running_enable_i(free),
      .accumulation_count_select_i(cur.acc), .reference_select_i(ref_sel),
      .clock_divider_select_i(cur.div), .input_channel_select_i(cur.ch),
      .event_start_enable_i(ev_en), .debug_run_enable_i(dbg_run), .sample_delay_i(cur.dly),
      .sample_delay_random_i(rnd), .window_cfg_i(cur.win), .result_ready_int_enable_i(cur.int_en),
      .start_conversion_cmd_i(start), .result_read_i(rd), .result_ready_clear_i(clr),
      .debug_halt_i(halt), .event_i(ev), .sar_data_i(sar_data), .start_conversion_cmd_o(busy),
      .result_o(result), .result_ready_flag_o(ready), .window_flag_o(win_flag), .irq_o(irq),
      .adc_clk_o(adc_clk), .sample_o(sample), .low_res_o(low_res), .analog_sel_o(sel));

   sar_analog_model u_sar_analog_model (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .sample_i(sample),
      .analog_sel_i(sel), .sar_data_o(sar_data));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic tick(input int k);
      repeat (k) @(negedge sys_clk_i);
   endtask
   task automatic do_reset();
      reset_n_i = 0;
      tick(2);
      reset_n_i = 1;
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      tick(1);
      s = 0;
   endtask
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Waits are bounded so a stuck converter ends the run instead of hanging it.
   task automatic wait_ready(output int k);
      k = 0;
      while (ready !== 1'b1 && k < 4000) begin
         tick(1);
         k++;
      end
      if (k >= 4000) begin
         failures++;
         $display("wrong value at %0t: ready never rose", $time);
         print_verdict();
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      do_reset();
      foreach (rows[i]) begin
         cur = rows[i];
         do_reset();
         tick(1);
         en = 1;
         tick(1);
         `CHECK(sel, {ref_sel, cur.ch})
         `CHECK(low_res, cur.res8)
         pulse(start);
         `CHECK(busy, 1'b1)
         wait_ready(cyc);
         n = 1 << cur.acc;
         d = 10'h3e0 + 10'(cur.ch);
         if (cur.res8) d = d >> 2;
         lo = (n * 13 + (n - 1) * cur.dly) << (cur.div + 1);
         `CHECK(result, 16'(n * d))
         `CHECK(cyc + 2 >= lo, 1'b1)
         `CHECK(irq, cur.exp_irq)
         `CHECK(win_flag, cur.exp_irq | ~cur.int_en)
         tick(1);
         `CHECK(busy, 1'b0)
         if (i % 2) pulse(rd);
         else pulse(clr);
         `CHECK(ready, 1'b0)
         `CHECK(win_flag, 1'b0)
         `CHECK(adc_clk, 1'b0)
         $display("row %0d done", i);
      end
      en = 0;
      ref_sel = 2'h3;
      do_reset();
      `CHECK(sel.reference_select, REF_INTERNAL)
      pulse(start);
      tick(2);
      `CHECK(busy, 1'b0)
      `CHECK(sel.reference_select, REF_INTERNAL)
      en = 1;
      ev = 1;
      tick(6);
      ev = 0;
      `CHECK(busy, 1'b0)
      tick(4);
      ev_en = 1;
      ev = 1;
      tick(6);
      `CHECK(busy, 1'b1)
      ev = 0;
      wait_ready(cyc);
      pulse(clr);
      $display("enable and event tests done");
      halt = 1;
      tick(4);
      pulse(start);
      tick(3);
      `CHECK(busy, 1'b0)
      dbg_run = 1;
      pulse(start);
      tick(2);
      `CHECK(busy, 1'b1)
      wait_ready(cyc);
      halt = 0;
      pulse(clr);
      $display("debug tests done");
      free = 1;
      pulse(start);
      wait_ready(cyc);
      pulse(clr);
      `CHECK(busy, 1'b1)
      wait_ready(cyc);
      `CHECK(ready, 1'b1)
      `CHECK(busy, 1'b1)
      en = 0;
      tick(3);
      `CHECK(busy, 1'b0)
      free = 0;
      en = 1;
      rnd = 1;
      cur.acc = 3'h1;
      cur.dly = 4'h5;
      pulse(clr);
      pulse(start);
      wait_ready(cyc);
      `CHECK(result, 16'(2 * (10'h3e0 + 10'(cur.ch))))
      $display("free-running and random delay tests done");
      print_verdict();
   end
endmodule
